// ===== frame_reject_info_store.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module frame_reject_info_store
    import frmr_store_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              local_frmr_sent,
    input  wire logic [15:0]       local_rejected_control_field,
    input  wire logic [6:0]        local_send_seq_var,
    input  wire logic [6:0]        local_recv_seq_var,
    input  wire logic              local_cmd_resp_flag,
    input  wire logic              local_undefined_control_flag,
    input  wire logic              local_illegal_info_flag,
    input  wire logic              local_oversize_info_flag,
    input  wire logic              local_bad_ack_number_flag,
    input  wire logic              remote_frmr_received,
    input  wire logic [15:0]       remote_rejected_control_field,
    input  wire logic [6:0]        remote_send_seq_var,
    input  wire logic [6:0]        remote_recv_seq_var,
    input  wire logic              remote_cmd_resp_flag,
    input  wire logic              remote_undefined_control_flag,
    input  wire logic              remote_illegal_info_flag,
    input  wire logic              remote_oversize_info_flag,
    input  wire logic              remote_bad_ack_number_flag,
    output logic                   mem_req,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [7:0]             mem_wdata,
    input  wire logic              mem_ack,
    output logic                   irq
);

    typedef struct packed {
        eng_state_t        eng;
        part_t             part;
        logic              mod128;
        logic [2:0]        idx;
        frmr_rec_t         act;
        frmr_rec_t         loc_rec;
        frmr_rec_t         rem_rec;
        logic              loc_pend;
        logic              rem_pend;
        logic              mem_req;
        logic [ADDR_W-1:0] mem_addr;
        logic [7:0]        mem_wdata;
        logic [1:0]        ctrl;
        logic [ADDR_W-1:0] base;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
    } store_state_t;

    store_state_t    st_reg;
    store_state_t    st_next;
    logic [7:0]      pk_byte;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic            status_clr_we;
    logic            mask_we;
    logic            transp;
    logic [2:0]      last_idx;
    logic            apb_done;

    // Flags are normalised so that the undefined flag excludes oversize and bad N(R).
    function automatic frmr_rec_t make_rec(input logic [15:0] cf, input logic [6:0] vs, input logic [6:0] vr,
                                           input logic cr, input logic un, input logic il,
                                           input logic ov, input logic nr);
        frmr_rec_t r;
        logic      w;
        w = un | il;
        r.ctrl = cf;
        r.vs = vs;
        r.vr = vr;
        r.cr = cr;
        r.flags[FLAG_UNDEF_BIT] = w;
        r.flags[FLAG_ILLEGAL_BIT] = il;
        r.flags[FLAG_OVERSIZE_BIT] = ov & ~w;
        r.flags[FLAG_BAD_NR_BIT] = nr & ~w;
        return r;
    endfunction : make_rec

    frmr_byte_packer u_packer (
        .rec      (st_reg.act),
        .mod128   (st_reg.mod128),
        .idx      (st_reg.idx),
        .byte_out (pk_byte)
    );

    frmr_event_irq u_irq (
        .clk           (clk),
        .rst_n         (rst_n),
        .set_events    (ev_set),
        .status_clr_we (status_clr_we),
        .mask_we       (mask_we),
        .wdata         (pwdata[EV_W-1:0]),
        .status        (ev_status),
        .mask          (ev_mask),
        .irq           (irq)
    );

    assign transp   = st_reg.ctrl[CTRL_TRANSP_BIT];
    assign last_idx = st_reg.mod128 ? FLAG_IDX_MOD128 : FLAG_IDX_MOD8;
    assign apb_done = psel & penable & st_reg.pready;
    assign status_clr_we = apb_done & pwrite & (paddr == STATUS_OFS);
    assign mask_we       = apb_done & pwrite & (paddr == MASK_OFS);

    always_comb
    begin
        st_next = st_reg;
        ev_set = STATUS_RESET;
        case (st_reg.eng)
            ENG_IDLE:
            begin
                if (!transp && (st_reg.loc_pend || st_reg.rem_pend))
                begin
                    st_next.eng = ENG_ISSUE;
                    st_next.idx = 3'h0;
                    st_next.mod128 = st_reg.ctrl[CTRL_MOD128_BIT];
                    if (st_reg.loc_pend)
                    begin
                        st_next.part = PART_LOCAL;
                        st_next.act = st_reg.loc_rec;
                        st_next.loc_pend = 1'b0;
                    end
                    else
                    begin
                        st_next.part = PART_REMOTE;
                        st_next.act = st_reg.rem_rec;
                        st_next.rem_pend = 1'b0;
                    end
                end
            end
            ENG_ISSUE:
            begin
                st_next.mem_req = 1'b1;
                st_next.mem_wdata = pk_byte;
                st_next.mem_addr = st_reg.base + ((st_reg.part == PART_REMOTE) ? REMOTE_PART_OFS : LOCAL_PART_OFS)
                                   + {21'h000000, st_reg.idx};
                st_next.eng = ENG_WAIT;
            end
            ENG_WAIT:
            begin
                if (mem_ack)
                begin
                    st_next.mem_req = 1'b0;
                    if (st_reg.idx == last_idx)
                    begin
                        st_next.eng = ENG_IDLE;
                        ev_set[EV_LOCAL_DONE] = (st_reg.part == PART_LOCAL);
                        ev_set[EV_REMOTE_DONE] = (st_reg.part == PART_REMOTE);
                    end
                    else
                    begin
                        st_next.idx = st_reg.idx + 3'h1;
                        st_next.eng = ENG_ISSUE;
                    end
                end
            end
            default:
            begin
                st_next.eng = ENG_IDLE;
                st_next.mem_req = 1'b0;
            end
        endcase
        if (local_frmr_sent && !transp)
        begin
            ev_set[EV_OVERRUN] = st_reg.loc_pend;
            st_next.loc_pend = 1'b1;
            st_next.loc_rec = make_rec(local_rejected_control_field, local_send_seq_var, local_recv_seq_var,
                                       local_cmd_resp_flag, local_undefined_control_flag,
                                       local_illegal_info_flag, local_oversize_info_flag,
                                       local_bad_ack_number_flag);
        end
        if (remote_frmr_received && !transp)
        begin
            ev_set[EV_OVERRUN] = ev_set[EV_OVERRUN] | st_reg.rem_pend;
            st_next.rem_pend = 1'b1;
            st_next.rem_rec = make_rec(remote_rejected_control_field, remote_send_seq_var, remote_recv_seq_var,
                                       remote_cmd_resp_flag, remote_undefined_control_flag,
                                       remote_illegal_info_flag, remote_oversize_info_flag,
                                       remote_bad_ack_number_flag);
        end
        // One wait state: read data and error are prepared with pready.
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (psel && penable && !st_reg.pready)
        begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h00000000;
            if (paddr == CTRL_OFS)
            begin
                st_next.prdata[1:0] = st_reg.ctrl;
            end
            else if (paddr == BASE_OFS)
            begin
                st_next.prdata[ADDR_W-1:0] = st_reg.base;
            end
            else if (paddr == STATUS_OFS)
            begin
                st_next.prdata[EV_W-1:0] = ev_status;
            end
            else if (paddr == MASK_OFS)
            begin
                st_next.prdata[EV_W-1:0] = ev_mask;
            end
            else if (paddr == ENGINE_OFS)
            begin
                st_next.prdata[2:0] = {st_reg.rem_pend, st_reg.loc_pend, (st_reg.eng != ENG_IDLE)};
            end
            else
            begin
                st_next.pslverr = 1'b1;
            end
        end
        if (apb_done && pwrite)
        begin
            if (paddr == CTRL_OFS)
            begin
                st_next.ctrl = pwdata[1:0];
            end
            else if (paddr == BASE_OFS)
            begin
                st_next.base = pwdata[ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '{eng: ENG_IDLE, part: PART_LOCAL, mod128: 1'b0, idx: 3'h0, act: REC_RESET,
                        loc_rec: REC_RESET, rem_rec: REC_RESET, loc_pend: 1'b0, rem_pend: 1'b0,
                        mem_req: 1'b0, mem_addr: BASE_RESET, mem_wdata: 8'h00, ctrl: CTRL_RESET,
                        base: BASE_RESET, pready: 1'b0, prdata: 32'h00000000, pslverr: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata    = st_reg.prdata;
    assign pready    = st_reg.pready;
    assign pslverr   = st_reg.pslverr;
    assign mem_req   = st_reg.mem_req;
    assign mem_addr  = st_reg.mem_addr;
    assign mem_wdata = st_reg.mem_wdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic loc_flag_byte;
    logic rem_flag_byte;
    assign loc_flag_byte = mem_req && (st_reg.part == PART_LOCAL) && (st_reg.idx == last_idx);
    assign rem_flag_byte = mem_req && (st_reg.part == PART_REMOTE) && (st_reg.idx == last_idx);

    sequence local_capture_s;
        local_frmr_sent && !transp && (st_reg.eng == ENG_IDLE) && !st_reg.loc_pend && !st_reg.rem_pend
            && !psel;
    endsequence

    sequence local_first_byte_s;
        mem_req && (st_reg.part == PART_LOCAL) && (st_reg.idx == 3'h0);
    endsequence

    sequence last_ack_s(part_t p);
        (st_reg.eng == ENG_WAIT) && mem_ack && (st_reg.idx == last_idx) && (st_reg.part == p);
    endsequence

    local_start_a: assert property (local_capture_s |-> ##[1:3] local_first_byte_s)
        else $error("local table fill did not start");
    remote_done_a: assert property (last_ack_s(PART_REMOTE) |=> ev_status[EV_REMOTE_DONE])
        else $error("remote done status not set");
    req_only_wait_a: assert property (mem_req |-> (st_reg.eng == ENG_WAIT))
        else $error("memory request outside write phase");
    transp_idle_a: assert property (transp && (st_reg.eng == ENG_IDLE) |=> !mem_req)
        else $error("table accessed in transparent mode");
    ctrl_byte_a: assert property (mem_req && (st_reg.idx == 3'h0) |->
        (mem_wdata == st_reg.act.ctrl[7:0]) && (mem_addr == st_reg.base
        + ((st_reg.part == PART_REMOTE) ? REMOTE_PART_OFS : LOCAL_PART_OFS)))
        else $error("control field byte wrong");
    ctrl_hi_a: assert property (mem_req && st_reg.mod128 && (st_reg.idx == 3'h1) |->
        mem_wdata == st_reg.act.ctrl[15:8])
        else $error("upper control byte wrong");
    loc_vs_a: assert property (mem_req && (st_reg.part == PART_LOCAL) && (st_reg.idx == 3'h1) && !st_reg.mod128
        |-> mem_wdata[3:1] == st_reg.act.vs[2:0])
        else $error("local send variable misplaced");
    loc_vr_a: assert property (mem_req && (st_reg.part == PART_LOCAL) && (st_reg.idx == 3'h3) && st_reg.mod128
        |-> mem_wdata[7:1] == st_reg.act.vr)
        else $error("local receive variable misplaced");
    loc_cr_a: assert property (local_frmr_sent && !transp |=> st_reg.loc_rec.cr == $past(local_cmd_resp_flag))
        else $error("local command response flag wrong");
    loc_undef_a: assert property (local_frmr_sent && !transp && local_undefined_control_flag
        |=> st_reg.loc_rec.flags[FLAG_UNDEF_BIT])
        else $error("local undefined flag missing");
    loc_illegal_a: assert property (loc_flag_byte && mem_wdata[FLAG_ILLEGAL_BIT] |-> mem_wdata[FLAG_UNDEF_BIT])
        else $error("local illegal flag without undefined flag");
    loc_oversize_a: assert property (loc_flag_byte |->
        !(mem_wdata[FLAG_OVERSIZE_BIT] && mem_wdata[FLAG_UNDEF_BIT]))
        else $error("local oversize with undefined flag");
    loc_bad_nr_a: assert property (loc_flag_byte |->
        !(mem_wdata[FLAG_BAD_NR_BIT] && mem_wdata[FLAG_UNDEF_BIT]))
        else $error("local bad N(R) with undefined flag");
    rem_vs_a: assert property (mem_req && (st_reg.part == PART_REMOTE) && (st_reg.idx == 3'h2) && st_reg.mod128
        |-> mem_wdata[7:1] == st_reg.act.vs)
        else $error("remote send variable misplaced");
    rem_vr_a: assert property (mem_req && (st_reg.part == PART_REMOTE) && (st_reg.idx == 3'h1) && !st_reg.mod128
        |-> mem_wdata[7:5] == st_reg.act.vr[2:0])
        else $error("remote receive variable misplaced");
    rem_cr_a: assert property (mem_req && (st_reg.part == PART_REMOTE) && (st_reg.idx == 3'h3) && st_reg.mod128
        |-> mem_wdata[0] == st_reg.act.cr)
        else $error("remote command response flag misplaced");
    rem_undef_a: assert property (remote_frmr_received && !transp && remote_undefined_control_flag
        |=> st_reg.rem_rec.flags[FLAG_UNDEF_BIT])
        else $error("remote undefined flag missing");
    rem_illegal_a: assert property (rem_flag_byte && mem_wdata[FLAG_ILLEGAL_BIT] |-> mem_wdata[FLAG_UNDEF_BIT])
        else $error("remote illegal flag without undefined flag");
    rem_oversize_a: assert property (rem_flag_byte |->
        !(mem_wdata[FLAG_OVERSIZE_BIT] && mem_wdata[FLAG_UNDEF_BIT]))
        else $error("remote oversize with undefined flag");
    rem_bad_nr_a: assert property (remote_frmr_received && !transp && remote_bad_ack_number_flag
        && !remote_undefined_control_flag && !remote_illegal_info_flag
        |=> st_reg.rem_rec.flags[FLAG_BAD_NR_BIT])
        else $error("remote bad N(R) flag missing");

endmodule : frame_reject_info_store

// ===== frmr_store_pkg.sv
package frmr_store_pkg;

    localparam int ADDR_W = 24;
    localparam int EV_W   = 3;

    // Register byte offsets on the APB.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] BASE_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS   = 8'h0C;
    localparam logic [7:0] ENGINE_OFS = 8'h10;

    // Control register fields.
    localparam int CTRL_MOD128_BIT = 0;
    localparam int CTRL_TRANSP_BIT = 1;

    // Event bits shared by the status and mask registers.
    localparam int EV_LOCAL_DONE  = 0;
    localparam int EV_REMOTE_DONE = 1;
    localparam int EV_OVERRUN     = 2;

    // Reset values.
    localparam logic [1:0]        CTRL_RESET   = 2'h0;
    localparam logic [ADDR_W-1:0] BASE_RESET   = 24'h000000;
    localparam logic [EV_W-1:0]   STATUS_RESET = 3'h0;
    localparam logic [EV_W-1:0]   MASK_RESET   = 3'h0;

    // Table layout: part offsets, byte indices and flag bit positions.
    localparam logic [ADDR_W-1:0] LOCAL_PART_OFS  = 24'h000000;
    localparam logic [ADDR_W-1:0] REMOTE_PART_OFS = 24'h000008;
    localparam logic [2:0]        FLAG_IDX_MOD8   = 3'h2;
    localparam logic [2:0]        FLAG_IDX_MOD128 = 3'h4;
    localparam int FLAG_UNDEF_BIT    = 0;
    localparam int FLAG_ILLEGAL_BIT  = 1;
    localparam int FLAG_OVERSIZE_BIT = 2;
    localparam int FLAG_BAD_NR_BIT   = 3;

    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_ISSUE = 2'b01,
        ENG_WAIT  = 2'b10
    } eng_state_t;

    typedef enum logic {
        PART_LOCAL  = 1'b0,
        PART_REMOTE = 1'b1
    } part_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [6:0]  vs;
        logic [6:0]  vr;
        logic        cr;
        logic [3:0]  flags;
    } frmr_rec_t;

    localparam frmr_rec_t REC_RESET = '0;

endpackage : frmr_store_pkg

// ===== frmr_byte_packer.sv
`timescale 1ns/1ps
module frmr_byte_packer
    import frmr_store_pkg::*;
(
    input  frmr_rec_t  rec,
    input  wire logic  mod128,
    input  wire logic [2:0] idx,
    output logic [7:0] byte_out
);

    always_comb
    begin
        byte_out = 8'h00;
        if (mod128)
        begin
            case (idx)
                3'h0:    byte_out = rec.ctrl[7:0];
                3'h1:    byte_out = rec.ctrl[15:8];
                3'h2:    byte_out = {rec.vs, 1'b0};
                3'h3:    byte_out = {rec.vr, rec.cr};
                3'h4:    byte_out = {4'h0, rec.flags};
                default: byte_out = 8'h00;
            endcase
        end
        else
        begin
            case (idx)
                3'h0:    byte_out = rec.ctrl[7:0];
                3'h1:    byte_out = {rec.vr[2:0], rec.cr, rec.vs[2:0], 1'b0};
                3'h2:    byte_out = {4'h0, rec.flags};
                default: byte_out = 8'h00;
            endcase
        end
    end

endmodule : frmr_byte_packer

// ===== frmr_event_irq.sv
`timescale 1ns/1ps
module frmr_event_irq
    import frmr_store_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [EV_W-1:0] set_events,
    input  wire logic            status_clr_we,
    input  wire logic            mask_we,
    input  wire logic [EV_W-1:0] wdata,
    output logic [EV_W-1:0]      status,
    output logic [EV_W-1:0]      mask,
    output logic                 irq
);

    typedef struct packed {
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic            irq;
    } irq_state_t;

    irq_state_t st_reg;
    irq_state_t st_next;

    // A new event in the clearing cycle survives the write of one.
    always_comb
    begin
        st_next = st_reg;
        st_next.status = (st_reg.status & ~(status_clr_we ? wdata : STATUS_RESET)) | set_events;
        if (mask_we)
        begin
            st_next.mask = wdata;
        end
        st_next.irq = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '{status: STATUS_RESET, mask: MASK_RESET, irq: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
    assign mask   = st_reg.mask;
    assign irq    = st_reg.irq;

endmodule : frmr_event_irq

// ===== frmr_mem_model.sv
`timescale 1ns/1ps
module frmr_mem_model
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mem_req,
    input  wire logic [23:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic [1:0]  lat,
    output logic             mem_ack
);
    logic [7:0]  mem [0:31];
    logic [23:0] last_addr;
    int          n_wr;
    logic [1:0]  wait_cnt;

    // The acknowledge comes after lat idle cycles, so slow memories are modelled too.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_ack  <= 1'b0;
            wait_cnt <= 2'h0;
        end
        else if (mem_req && !mem_ack && wait_cnt >= lat)
        begin
            mem_ack  <= 1'b1;
            wait_cnt <= 2'h0;
        end
        else
        begin
            mem_ack  <= 1'b0;
            wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
        end
    end

    // device-only writes
    // Only the device stores into the table; the host never writes it.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            n_wr <= 0;
        end
        else if (mem_req && mem_ack)
        begin
            mem[mem_addr[4:0]] <= mem_wdata;
            last_addr          <= mem_addr;
            n_wr               <= n_wr + 1;
        end
    end
endmodule : frmr_mem_model

// ===== frame_reject_info_store_tb_top.sv
`timescale 1ns/1ps
module frame_reject_info_store_tb_top
    import frmr_store_pkg::*;
;
    typedef struct packed {
        logic      m128;
        part_t     part;
        frmr_rec_t rec;
        logic [1:0] lat;
    } row_t;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, mem_req, mem_ack, irq, loc = 1'b0, rem = 1'b0, er;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [1:0]  lat = 2'h0;
    frmr_rec_t   lv = '0, rv = '0;
    row_t        rows [6];
    int          n_errors = 0, samples_checked = 0, cyc = 0, n0, nb, ofs;
    localparam logic [ADDR_W-1:0] BASE = 24'h001000;

    frame_reject_info_store frame_reject_info_store_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_frmr_sent(loc), .local_rejected_control_field(lv.ctrl), .local_send_seq_var(lv.vs),
        .local_recv_seq_var(lv.vr), .local_cmd_resp_flag(lv.cr), .local_undefined_control_flag(lv.flags[0]),
        .local_illegal_info_flag(lv.flags[1]), .local_oversize_info_flag(lv.flags[2]),
        .local_bad_ack_number_flag(lv.flags[3]), .remote_frmr_received(rem), .remote_rejected_control_field(rv.ctrl),
        .remote_send_seq_var(rv.vs), .remote_recv_seq_var(rv.vr), .remote_cmd_resp_flag(rv.cr),
        .remote_undefined_control_flag(rv.flags[0]), .remote_illegal_info_flag(rv.flags[1]),
        .remote_oversize_info_flag(rv.flags[2]), .remote_bad_ack_number_flag(rv.flags[3]), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .irq(irq));
    frmr_mem_model frmr_mem_model_i (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    task automatic test_done();
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            n_errors = n_errors + 1;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk("read data", rd, exp);
        chk("slave error", {31'h0, er}, {31'h0, err});
    endtask : rd_chk

    task automatic send(input row_t r);
        @(posedge clk);
        lv  <= (r.part == PART_LOCAL) ? r.rec : ~r.rec;
        rv  <= (r.part == PART_LOCAL) ? ~r.rec : r.rec;
        loc <= (r.part == PART_LOCAL);
        rem <= (r.part == PART_REMOTE);
        @(posedge clk);
        loc <= 1'b0;
        rem <= 1'b0;
    endtask : send

    function automatic logic [7:0] exp_b(input row_t r, input int i);
        logic w;
        logic [7:0] fl;
        w  = r.rec.flags[FLAG_UNDEF_BIT] | r.rec.flags[FLAG_ILLEGAL_BIT];
        fl = {4'h0, r.rec.flags[FLAG_BAD_NR_BIT] & !w, r.rec.flags[FLAG_OVERSIZE_BIT] & !w,
              r.rec.flags[FLAG_ILLEGAL_BIT], w};
        if (!r.m128)
            return (i == 0) ? r.rec.ctrl[7:0] : (i == 1) ? {r.rec.vr[2:0], r.rec.cr, r.rec.vs[2:0], 1'b0} : fl;
        return (i == 0) ? r.rec.ctrl[7:0] : (i == 1) ? r.rec.ctrl[15:8] : (i == 2) ? {r.rec.vs, 1'b0}
             : (i == 3) ? {r.rec.vr, r.rec.cr} : fl;
    endfunction : exp_b

    task automatic check_part(input row_t r);
        nb  = r.m128 ? 5 : 3;
        ofs = (r.part == PART_REMOTE) ? 8 : 0;
        chk("byte count", 32'(frmr_mem_model_i.n_wr - n0), 32'(nb));
        chk("last address", 32'(frmr_mem_model_i.last_addr), 32'(BASE + 24'(ofs + nb - 1)));
        for (int i = 0; i < nb; i++)
            chk("table byte", 32'(frmr_mem_model_i.mem[ofs + i]), 32'(exp_b(r, i)));
    endtask : check_part

    initial
    begin
        rows[0] = '{1'b0, PART_LOCAL,  '{16'h00A3, 7'h05, 7'h02, 1'b1, 4'h1}, 2'h0};
        rows[1] = '{1'b0, PART_LOCAL,  '{16'h005C, 7'h03, 7'h06, 1'b0, 4'hC}, 2'h1};
        rows[2] = '{1'b1, PART_LOCAL,  '{16'hB7E1, 7'h5A, 7'h33, 1'b1, 4'h2}, 2'h0};
        rows[3] = '{1'b0, PART_REMOTE, '{16'h0091, 7'h07, 7'h01, 1'b1, 4'h5}, 2'h2};
        rows[4] = '{1'b1, PART_REMOTE, '{16'h4C2D, 7'h21, 7'h7E, 1'b0, 4'h8}, 2'h0};
        rows[5] = '{1'b1, PART_REMOTE, '{16'hE00F, 7'h7F, 7'h40, 1'b1, 4'hA}, 2'h3};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[k]) rd_chk(8'(4 * k), 32'h0, k == 5);
        rd_chk(8'h20, 32'h0, 1'b1);
        apb(1'b1, BASE_OFS, 32'(BASE));
        apb(1'b1, MASK_OFS, 32'h3);
        foreach (rows[k])
        begin
            apb(1'b1, CTRL_OFS, {31'h0, rows[k].m128});
            lat <= rows[k].lat;
            n0  = frmr_mem_model_i.n_wr;
            send(rows[k]);
            while (irq !== 1'b1) @(posedge clk);
            check_part(rows[k]);
            rd_chk(STATUS_OFS, (rows[k].part == PART_REMOTE) ? 32'h2 : 32'h1, 1'b0);
            apb(1'b1, STATUS_OFS, 32'h7);
            @(posedge clk);
            chk("irq cleared", {31'h0, irq}, 32'h0);
        end
        apb(1'b1, CTRL_OFS, 32'h2);
        n0 = frmr_mem_model_i.n_wr;
        send(rows[0]);
        repeat (12) @(posedge clk);
        chk("transparent writes", 32'(frmr_mem_model_i.n_wr - n0), 32'h0);
        rd_chk(ENGINE_OFS, 32'h0, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0);
        lat <= 2'h3;
        n0 = frmr_mem_model_i.n_wr + 3;
        send(rows[3]);
        repeat (4) @(posedge clk);
        send(rows[0]);
        send(rows[1]);
        repeat (80) @(posedge clk);
        rd_chk(STATUS_OFS, 32'h7, 1'b0);
        check_part(rows[1]);
        apb(1'b1, MASK_OFS, 32'h0);
        @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, STATUS_OFS, 32'h7);
        rd_chk(STATUS_OFS, 32'h0, 1'b0);
        test_done();
    end
endmodule : frame_reject_info_store_tb_top
